//--- include/uart_rx_consts.svh
// constants for the serial receiver with baud timer
// assumes a 32-bit apb slave, registers one word each
`ifndef UART_RX_CONSTS_SVH
`define UART_RX_CONSTS_SVH

// register byte offsets
`define OFS_CTRL     12'h000
`define OFS_STATUS   12'h004
`define OFS_DATA     12'h008
`define OFS_DIV_LO   12'h00C
`define OFS_DIV_HI   12'h010

// control field positions
`define CTRL_PORT_EN    0
`define CTRL_RECV_EN    1
`define CTRL_NINE_BIT   2
`define CTRL_ADDR_DET   3
`define CTRL_HIGH_SPEED 4
`define CTRL_WIDE    5
`define CTRL_SYNC    6

// status field positions
`define ST_FRAMING    0
`define ST_OVERRUN    1
`define ST_NINTH_BIT  2
`define ST_DATA_AVAIL 3
`define ST_IDLE      4

// reset values
`define CTRL_RST     8'h00
`define DIV_RST      8'h00

// receive FIFO depth
`define FIFO_DEPTH   2

`endif

//--- include/uart_rx_pkg.sv
// types for the serial receiver
// assumes the constants header is included beside it
package uart_rx_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef logic [9:0] fifo_word_t;  // framing flag, ninth bit, bits 7..0
endpackage

//--- hdl/rx_fifo.sv
// two-entry receive FIFO, read word registered
// assumes synchronous push and pop, clear from serial port disable
`timescale 1ns/1ps
`include "uart_rx_consts.svh"
module rx_fifo
  import uart_rx_pkg::*;
#(
  parameter int DEPTH = `FIFO_DEPTH
)
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       clr,
  input  wire logic       push,
  input  wire fifo_word_t push_data,
  input  wire logic       pop,
  // status
  output logic            full,
  output logic            empty,
  output fifo_word_t      top_data
);
  // refuse depths the shift-out slots cannot hold
  if (DEPTH != 2)
  begin : g_depth_check
    $error("rx_fifo supports depth 2 only");
  end

  fifo_word_t mem_r [2];
  fifo_word_t mem_nxt [2];
  logic [1:0] cnt_r, cnt_nxt;

  ////////////////////////////////////////////////////////////////////
  // next state: shift-out FIFO, head always in slot 0
  always_comb
  begin
    mem_nxt = mem_r;
    cnt_nxt = cnt_r;
    if (clr)
    begin
      cnt_nxt = 2'h0;
    end
    else
    begin
      if (pop && cnt_r != 2'h0)
      begin
        mem_nxt[0] = mem_r[1];
        cnt_nxt = cnt_r - 2'h1;
      end
      if (push && cnt_nxt != 2'h2)
      begin
        mem_nxt[cnt_nxt[0]] = push_data;
        cnt_nxt = cnt_nxt + 2'h1;
      end
    end
  end

  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_r[0] <= 10'h000;
      mem_r[1] <= 10'h000;
      cnt_r    <= 2'h0;
    end
    else
    begin
      mem_r <= mem_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign full     = (cnt_r == 2'h2);
  assign empty    = (cnt_r == 2'h0);
  assign top_data = mem_r[0];
endmodule // rx_fifo

//--- hdl/baud_timer.sv
// free-running 8/16-bit baud timer producing a sample tick
// assumes divisor writes pulse wr_div for one cycle
`timescale 1ns/1ps
`include "uart_rx_consts.svh"
module baud_timer
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic        enable,
  input  wire logic        wide,
  input  wire logic [15:0] divisor,
  input  wire logic        wr_div,
  // tick, one per limit+1 cycles, limit being divisor or, in 8-bit mode, its low byte
  output logic             tick
);
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] limit;

  // 8-bit mode uses only the low byte
  assign limit = wide ? divisor : {8'h00, divisor[7:0]};

  // count up to the limit, then restart at zero; write clears the count
  always_comb
  begin
    tick    = 1'b0;
    cnt_nxt = cnt_r;
    if (!enable || wr_div)                         // R18 R20
      cnt_nxt = 16'h0000;
    else if (cnt_r >= limit)
    begin
      cnt_nxt = 16'h0000;
      tick    = 1'b1;
    end
    else
      cnt_nxt = cnt_r + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= 16'h0000;
    else
      cnt_r <= cnt_nxt;
  end

  a_tick_period: assert property (@(posedge pclk) disable iff (!presetn) // R16
    tick |=> !tick || (limit == 16'h0000)) else $error("tick too close");
endmodule // baud_timer

//--- hdl/uart_rx.sv
// receive side of the serial transceiver with apb registers
// assumes an apb master on pclk, rx pin synchronous to pclk
//
// Overview of operation
// [R1] each stored character keeps its framing flag
// [R2] framing status follows oldest unread character
// [R3] framing status read-only, reception continues
// [R4] port disable clears framing, receive-disable keeps
// [R5] framing error raises no interrupt
// [R6] all-errored FIFO keeps framing status set
// [R7] software reads framing status before data
// [R8] two-deep FIFO, third character sets overrun
// [R9] overrun keeps FIFO readable, blocks reception
// [R10] overrun cleared by receive or port disable
// [R11] nine-bit mode captures ninth bit status
// [R12] software reads ninth bit before data
// [R13] address detect admits ninth-bit-set characters only
// [R14] software toggles address detect per message
// [R15] baud timer eight or sixteen bits wide
// [R16] divisor and mode bits pick period multiplier
// [R17] async low-speed 8-bit: clock over 64(n+1)
// [R18] divisor write clears baud timer
// [R19] receiver idle status bit provided
// [R20] port disable empties FIFO, idles receiver
`timescale 1ns/1ps
`include "uart_rx_consts.svh"
module uart_rx
  import uart_rx_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial line
  input  wire logic        rx_pin,
  // receive interrupt flag level
  output logic             receive_interrupt_flag
);
  ////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0]  ctrl_r, ctrl_nxt;
  logic [7:0]  div_lo_r, div_lo_nxt;
  logic [7:0]  div_hi_r, div_hi_nxt;
  logic        ovr_r, ovr_nxt;
  logic [31:0] prdata_r, prdata_nxt;

  logic wr_en, rd_en, wr_div, pop;
  logic serial_port_enable, continuous_receive_enable;
  logic nine_bit_receive_enable, address_detect_enable;
  logic high_speed_select, wide_timer_select, sync_mode;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = prdata_r;

  assign serial_port_enable        = ctrl_r[`CTRL_PORT_EN];
  assign continuous_receive_enable = ctrl_r[`CTRL_RECV_EN];
  assign nine_bit_receive_enable   = ctrl_r[`CTRL_NINE_BIT];
  assign address_detect_enable     = ctrl_r[`CTRL_ADDR_DET];
  assign high_speed_select         = ctrl_r[`CTRL_HIGH_SPEED];
  assign wide_timer_select         = ctrl_r[`CTRL_WIDE];
  assign sync_mode                 = ctrl_r[`CTRL_SYNC];

  assign wr_div = wr_en && (paddr == `OFS_DIV_LO || paddr == `OFS_DIV_HI); // R18
  assign pop    = rd_en && (paddr == `OFS_DATA);                            // R2

  ////////////////////////////////////////////////////////////////////
  // baud timer and oversampling divider
  logic       bt_tick;
  logic [5:0] os_r, os_nxt;
  logic [5:0] os_max;
  logic       sample_tick;

  baud_timer u_baud
  (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (serial_port_enable),
    .wide    (wide_timer_select),                 // R15
    .divisor ({div_hi_r, div_lo_r}),
    .wr_div  (wr_div),
    .tick    (bt_tick)
  );

  // multiplier: 64, 16 or 4 timer periods per bit, split in 4 phases
  always_comb
  begin
    if (sync_mode || (high_speed_select && wide_timer_select))
      os_max = 6'h00;                              // 4 per bit
    else if (high_speed_select || wide_timer_select)
      os_max = 6'h03;                              // 16 per bit
    else
      os_max = 6'h0F;                              // 64 per bit R17
  end

  // prescale to one quarter-bit tick
  always_comb
  begin
    sample_tick = 1'b0;
    os_nxt      = os_r;
    if (!serial_port_enable || wr_div)
      os_nxt = 6'h00;
    else if (bt_tick)
    begin
      if (os_r >= os_max)
      begin
        os_nxt      = 6'h00;
        sample_tick = 1'b1;                        // R16
      end
      else
        os_nxt = os_r + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receive state machine, four ticks per bit, sample at phase 1
  rx_state_t  st_r, st_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [8:0] shift_r, shift_nxt;
  logic       push;
  fifo_word_t push_data;
  logic       fifo_full, fifo_empty;
  fifo_word_t top;
  logic       rx_on, stop_bad, admit;

  assign rx_on = serial_port_enable && continuous_receive_enable && !ovr_r; // R9

  always_comb
  begin
    st_nxt    = st_r;
    ph_nxt    = ph_r;
    bit_nxt   = bit_r;
    shift_nxt = shift_r;
    push      = 1'b0;
    stop_bad  = 1'b0;
    admit     = 1'b0;
    push_data = {1'b0, shift_r};
    if (!rx_on)
      st_nxt = RX_IDLE;
    else if (st_r == RX_IDLE)
    begin
      if (!rx_pin)
      begin
        st_nxt = RX_START;
        ph_nxt = 2'h0;
      end
    end
    else if (sample_tick)
    begin
      ph_nxt = ph_r + 2'h1;
      case (st_r)
        RX_START:
        begin
          if (ph_r == 2'h1 && rx_pin)
            st_nxt = RX_IDLE;                      // false start
          else if (ph_r == 2'h3)
          begin
            st_nxt  = RX_DATA;
            bit_nxt = 4'h0;
          end
        end
        RX_DATA:
        begin
          if (ph_r == 2'h1)
            shift_nxt = nine_bit_receive_enable ? {rx_pin, shift_r[8:1]}
                                                : {1'b0, rx_pin, shift_r[7:1]}; // R11
          if (ph_r == 2'h3)
          begin
            bit_nxt = bit_r + 4'h1;
            if (bit_r == (nine_bit_receive_enable ? 4'h8 : 4'h7))
              st_nxt = RX_STOP;
          end
        end
        RX_STOP:
        begin
          if (ph_r == 2'h1)
          begin
            stop_bad  = !rx_pin;                   // R1
            push_data = {stop_bad, shift_r};       // R1
            admit = !(address_detect_enable && nine_bit_receive_enable && !shift_r[8]); // R13
            push  = admit && (!fifo_full || pop);  // R8 a read frees a slot
            st_nxt = RX_IDLE;                      // R3
          end
        end
        default: st_nxt = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r    <= RX_IDLE;
      ph_r    <= 2'h0;
      bit_r   <= 4'h0;
      shift_r <= 9'h000;
      os_r    <= 6'h00;
    end
    else
    begin
      st_r    <= st_nxt;
      ph_r    <= ph_nxt;
      bit_r   <= bit_nxt;
      shift_r <= shift_nxt;
      os_r    <= os_nxt;
    end
  end

  rx_fifo #(.DEPTH(`FIFO_DEPTH)) u_fifo
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .clr       (!serial_port_enable),              // R20 R4
    .push      (push),
    .push_data (push_data),
    .pop       (pop),
    .full      (fifo_full),
    .empty     (fifo_empty),
    .top_data  (top)
  );

  // interrupt flag only tracks data presence, not errors
  assign receive_interrupt_flag = !fifo_empty;     // R5

  ////////////////////////////////////////////////////////////////////
  // register writes, overrun flag, read data
  logic ov_event;
  assign ov_event = (st_r == RX_STOP) && sample_tick && (ph_r == 2'h1) && admit && fifo_full
                    && !pop;                       // R8

  always_comb
  begin
    ctrl_nxt   = ctrl_r;
    div_lo_nxt = div_lo_r;
    div_hi_nxt = div_hi_r;
    ovr_nxt    = ovr_r;
    prdata_nxt = prdata_r;
    if (wr_en && paddr == `OFS_CTRL)   ctrl_nxt   = pwdata[7:0];
    if (wr_en && paddr == `OFS_DIV_LO) div_lo_nxt = pwdata[7:0];
    if (wr_en && paddr == `OFS_DIV_HI) div_hi_nxt = pwdata[7:0];
    if (!serial_port_enable || !continuous_receive_enable)
      ovr_nxt = 1'b0;                              // R10
    else if (ov_event)
      ovr_nxt = 1'b1;                              // R8
    if (psel && !penable && !pwrite)
    begin
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        `OFS_CTRL:   prdata_nxt[7:0] = ctrl_r;
        `OFS_STATUS:
        begin
          prdata_nxt[`ST_FRAMING]    = !fifo_empty && top[9];  // R2 R6
          prdata_nxt[`ST_OVERRUN]    = ovr_r;
          prdata_nxt[`ST_NINTH_BIT]  = !fifo_empty && top[8];  // R11
          prdata_nxt[`ST_DATA_AVAIL] = !fifo_empty;
          prdata_nxt[`ST_IDLE] = (st_r == RX_IDLE);      // R19
        end
        `OFS_DATA:   prdata_nxt[7:0] = top[7:0];
        `OFS_DIV_LO: prdata_nxt[7:0] = div_lo_r;
        `OFS_DIV_HI: prdata_nxt[7:0] = div_hi_r;
        default:     prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r   <= `CTRL_RST;
      div_lo_r <= `DIV_RST;
      div_hi_r <= `DIV_RST;
      ovr_r    <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      ctrl_r   <= ctrl_nxt;
      div_lo_r <= div_lo_nxt;
      div_hi_r <= div_hi_nxt;
      ovr_r    <= ovr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  a_overrun_blocks: assert property (@(posedge pclk) disable iff (!presetn) // R9
    ovr_r |-> !push) else $error("push during overrun");
  a_overrun_sets: assert property (@(posedge pclk) disable iff (!presetn) // R8
    ov_event && continuous_receive_enable && serial_port_enable |=> ovr_r)
    else $error("overrun not flagged");
  a_overrun_clear: assert property (@(posedge pclk) disable iff (!presetn) // R10
    !continuous_receive_enable |=> !ovr_r) else $error("overrun kept");
  a_disable_empties: assert property (@(posedge pclk) disable iff (!presetn) // R20
    !serial_port_enable |=> fifo_empty && st_r == RX_IDLE) else $error("not flushed");
  a_push_stored: assert property (@(posedge pclk) disable iff (!presetn) // R1
    push |=> !fifo_empty && (!$past(fifo_empty) || top == $past(push_data)))
    else $error("character or flag not stored");
  a_addr_filter: assert property (@(posedge pclk) disable iff (!presetn) // R13
    push && address_detect_enable && nine_bit_receive_enable |-> push_data[8])
    else $error("address filter leak");
  a_data_flag_level: assert property (@(posedge pclk) disable iff (!presetn) // R5
    receive_interrupt_flag == !fifo_empty) else $error("flag mismatch");
  a_div_clears: assert property (@(posedge pclk) disable iff (!presetn) // R18
    wr_div |=> os_r == 6'h00) else $error("prescaler not cleared");
endmodule // uart_rx

//--- sim/serial_tx_model.sv
// remote serial transmitter driving the shared receive line
// assumes the caller gives the bit time in pclk cycles
`timescale 1ns/1ps
module serial_tx_model
(
  // clock
  input  wire logic pclk,
  // serial line, idles high
  output logic      line
);
  initial line = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // one frame: start, data lsb first, stop, then idle gap
  task automatic send(input logic [8:0] d, input int nbits, input bit stop_ok, input int bt);
    int i;
    @(posedge pclk);
    line <= 1'b0;
    repeat (bt) @(posedge pclk);
    for (i = 0; i < nbits; i++)
    begin
      line <= d[i];
      repeat (bt) @(posedge pclk);
    end
    // a bad stop stays low past its sample point only
    line <= stop_ok;
    repeat (bt * 3 / 4) @(posedge pclk);
    line <= 1'b1;
    repeat (bt / 4 + 2 * bt) @(posedge pclk);
  endtask
endmodule // serial_tx_model

//--- sim/tb_uart_rx_errors_and_baud_gen.sv
// testbench for the serial receiver: apb tasks and frame scenarios
// assumes serial_tx_model drives the line and pready answers
`timescale 1ns/1ps
`include "uart_rx_consts.svh"
module tb_uart_rx_errors_and_baud_gen;
  import uart_rx_pkg::*;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_pin;
  logic        irq_flag;
  int          bad_count = 0;
  int          checked   = 0;
  int          cycles    = 0;
  int          i;
  localparam int BT = 16;  // fast mode, divisor 3
  // per multiplier pass: control, divisor low, divisor high; 64 cycles a bit
  logic [31:0] pass_ctrl [4] = '{32'h03, 32'h23, 32'h13, 32'h53};
  logic [31:0] pass_dlo  [4] = '{32'h00, 32'h03, 32'h03, 32'h0F};
  logic [31:0] pass_dhi  [4] = '{32'h01, 32'h00, 32'h00, 32'h00};

  always #5 pclk = ~pclk;

  uart_rx DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pin(rx_pin), .receive_interrupt_flag(irq_flag));
  serial_tx_model tx (.pclk(pclk), .line(rx_pin));

  ////////////////////////////////////////////////////////////////////////////////
  // comparison, apb cycles and status checks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    check({31'h0, pslverr}, 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check(r, exp);
  endtask

  // status low nibble: framing, overrun, ninth bit, data available
  task automatic st_chk(input logic f, input logic o, input logic n, input logic a);
    logic [31:0] r;
    apb(1'b0, `OFS_STATUS, 32'h0, r);
    check(r & 32'h0F, {28'h0, a, n, o, f});
  endtask

  task automatic flag_chk(input logic exp);
    #1;
    check({31'h0, irq_flag}, {31'h0, exp});
  endtask

  task automatic finish_test;
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      bad_count++;
      finish_test;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`OFS_CTRL, 32'h0);
    rd_chk(12'h014, 32'h0);
    wr(`OFS_DIV_LO, 32'h3);
    wr(`OFS_DIV_HI, 32'h0);
    wr(`OFS_CTRL, 32'h33);
    // good then bad stop; flag follows the oldest character
    tx.send(9'h0A5, 8, 1'b1, BT);
    tx.send(9'h03C, 8, 1'b0, BT);
    flag_chk(1'b1);
    st_chk(1'b0, 1'b0, 1'b0, 1'b1);
    rd_chk(`OFS_DATA, 32'hA5);
    st_chk(1'b1, 1'b0, 1'b0, 1'b1);
    rd_chk(`OFS_DATA, 32'h3C);
    st_chk(1'b0, 1'b0, 1'b0, 1'b0);
    flag_chk(1'b0);
    // every held character errored
    tx.send(9'h011, 8, 1'b0, BT);
    tx.send(9'h022, 8, 1'b0, BT);
    rd_chk(`OFS_DATA, 32'h11);
    st_chk(1'b1, 1'b0, 1'b0, 1'b1);
    rd_chk(`OFS_DATA, 32'h22);
    // third character overruns, fourth is refused
    tx.send(9'h081, 8, 1'b0, BT);
    tx.send(9'h042, 8, 1'b1, BT);
    tx.send(9'h099, 8, 1'b1, BT);
    st_chk(1'b1, 1'b1, 1'b0, 1'b1);
    tx.send(9'h077, 8, 1'b1, BT);
    wr(`OFS_CTRL, 32'h31);
    st_chk(1'b1, 1'b0, 1'b0, 1'b1);
    wr(`OFS_CTRL, 32'h33);
    rd_chk(`OFS_DATA, 32'h81);
    rd_chk(`OFS_DATA, 32'h42);
    st_chk(1'b0, 1'b0, 1'b0, 1'b0);
    // port disable clears framing and empties the fifo
    tx.send(9'h05F, 8, 1'b0, BT);
    st_chk(1'b1, 1'b0, 1'b0, 1'b1);
    wr(`OFS_CTRL, 32'h32);
    st_chk(1'b0, 1'b0, 1'b0, 1'b0);
    flag_chk(1'b0);
    // nine-bit reception
    wr(`OFS_CTRL, 32'h37);
    tx.send(9'h1AB, 9, 1'b1, BT);
    st_chk(1'b0, 1'b0, 1'b1, 1'b1);
    rd_chk(`OFS_DATA, 32'hAB);
    rd_chk(`OFS_STATUS, 32'h10) ;
    // address filtering
    wr(`OFS_CTRL, 32'h3F);
    tx.send(9'h055, 9, 1'b1, BT);
    flag_chk(1'b0);
    tx.send(9'h1C3, 9, 1'b1, BT);
    st_chk(1'b0, 1'b0, 1'b1, 1'b1);
    wr(`OFS_CTRL, 32'h37);
    tx.send(9'h012, 9, 1'b1, BT);
    rd_chk(`OFS_DATA, 32'hC3);
    st_chk(1'b0, 1'b0, 1'b0, 1'b1);
    rd_chk(`OFS_DATA, 32'h12);
    // rate multipliers: low 8-bit div 0 with high byte unused, wide div 3,
    // high speed div 3, sync with high speed ignored div 15
    for (i = 0; i < 4; i++)
    begin
      wr(`OFS_CTRL, pass_ctrl[i]);
      wr(`OFS_DIV_LO, pass_dlo[i]);
      wr(`OFS_DIV_HI, pass_dhi[i]);
      tx.send(9'h05A + i[8:0], 8, 1'b1, 64);
      rd_chk(`OFS_DATA, 32'h5A + i);
    end
    finish_test;
  end
endmodule // tb_uart_rx_errors_and_baud_gen
